//--- common/atpc_pkg.sv
package atpc_pkg;
    // Register offsets
    localparam logic [7:0] OFS_MISC = 8'h3B;
    localparam logic [7:0] OFS_TONE = 8'h3F;
    localparam logic [7:0] OFS_BST  = 8'h40;
    localparam logic [7:0] OFS_PDM  = 8'h41;
    localparam logic [7:0] OFS_PULL = 8'h42;
    localparam logic [7:0] OFS_SP2  = 8'h43;
    // Reset values
    localparam logic [7:0] RST_MISC = 8'h58;
    localparam logic [7:0] RST_TONE = 8'h00;
    localparam logic [7:0] RST_BST  = 8'h36;
    localparam logic [7:0] RST_PDM  = 8'h41;
    localparam logic [7:0] RST_PULL = 8'h00;
    localparam logic [7:0] RST_SP2  = 8'h08;
    // Writable bit masks, read-only bits stay at reset
    localparam logic [7:0] WMSK_TONE = 8'hF0;
    localparam logic [7:0] WMSK_PDM  = 8'h7F;
    localparam logic [7:0] WMSK_PULL = 8'hD8;
    localparam logic [7:0] WMSK_SP2  = 8'hF8;
    // Field positions
    localparam int BIT_HAPTIC   = 7;
    localparam int POS_TONE_EN  = 6;
    localparam int POS_TONE_SRC = 4;
    localparam int BIT_GATE     = 6;
    localparam int BIT_RATE     = 5;
    localparam int BIT_ERRDIS   = 4;
    localparam int BIT_EDGE     = 3;
    localparam int BIT_SECOND_MICROPHONE     = 2;
    localparam int BIT_FIRST_MICROPHONE     = 1;
    localparam int BIT_ROLE     = 0;
    localparam int BIT_PD_IN2   = 7;
    localparam int BIT_PD_IN1   = 6;
    localparam int BIT_PD_DATA  = 4;
    localparam int BIT_PD_CLK   = 3;
    localparam int BIT_SP2_FILL = 7;
    localparam int POS_SP2_RAT  = 3;
    // Boost limit scale in milliamps
    localparam logic [5:0]  BST_MAX_CODE = 6'h37;
    localparam logic [12:0] BST_BASE_MA  = 13'd990;
    localparam logic [12:0] BST_STEP_MA  = 13'd55;
    localparam logic [12:0] BST_TOP_MA   = 13'd4000;
    // Timing
    localparam int CLK_KHZ      = 25000;
    localparam int RATE_LO_KHZ  = 3072;
    localparam int RATE_HI_KHZ  = 6144;
    localparam int HALF_LO      = CLK_KHZ / (2 * RATE_LO_KHZ);
    localparam int HALF_HI      = CLK_KHZ / (2 * RATE_HI_KHZ);
    localparam int ERR_TIME_NS  = 1000;
    localparam int ERR_CYC      = ERR_TIME_NS * CLK_KHZ / 1000000;
    // Tone enable codes
    typedef enum logic [1:0] {
        TONE_OFF, TONE_PLAY, TONE_LEVEL, TONE_RSVD
    } atpc_tone_t;
endpackage : atpc_pkg

//--- tb/atpc_mic_model.sv
`timescale 1ns/1ps
`default_nettype none
// Microphone on the PDM pad, also the outside clock source
module atpc_mic_model (
    // Clock
    input  wire logic core_clk,
    // Bench control
    input  wire logic clkRun,
    // Pad
    output var logic  pdmClkIn,
    output var logic  pdmDataIn
);
    logic [1:0] divCnt;

    // Known start so the follower sees a clean level
    initial begin
        pdmClkIn = 1'b0;
        pdmDataIn = 1'b0;
        divCnt = 2'h0;
    end

    // Clock only runs in a burst, so a stall is a real stall
    always @(negedge core_clk) begin
        divCnt <= divCnt + 2'h1;
        if (clkRun && divCnt == 2'h3) begin
            pdmClkIn <= ~pdmClkIn;
        end
        // Data never holds, so a stale sample cannot pass
        pdmDataIn <= ~pdmDataIn;
    end
endmodule : atpc_mic_model
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import atpc_pkg::*;
    logic        core_clk, nrst, regWrEn, regRdEn, pin0, pin1, pin2, clkRun;
    logic [7:0]  regAddr, regWrData, regRdData;
    logic        vib, toneAct, toneLvl, valid, clkIn, dataIn, clkOut, oe;
    logic        m1v, m2v, err, pd1, pd2, pdd, pdc, edgeLvl;
    logic        m1d, m2d, fill;
    logic [5:0]  code;
    logic [3:0]  ratio;
    logic [12:0] ma;
    int          num_errors, total_checks, n1, n2, badEdge, hiCnt, i;
    // Address, reset value, write data, read-back value
    logic [7:0]  rows [7][4] = '{'{OFS_MISC, RST_MISC, 8'hFF, 8'hFF},
        '{OFS_TONE, RST_TONE, 8'hFF, 8'hF0}, '{OFS_BST, RST_BST, 8'h37, 8'h37},
        '{OFS_PDM, RST_PDM, 8'hFF, 8'h7F}, '{OFS_PULL, RST_PULL, 8'hFF, 8'hD8},
        '{OFS_SP2, RST_SP2, 8'hFF, 8'hF8}, '{8'h50, 8'h00, 8'hFF, 8'h00}};

    atpc_config_regs uut (.core_clk(core_clk), .nrst(nrst), .regAddr(regAddr),
        .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
        .audioSerialInputPin(pin0), .gpioPin(pin1), .addressSelectPin(pin2),
        .vibrationModeOn(vib), .toneActive(toneAct), .toneAudioLevel(toneLvl),
        .boostPeakCurrentCode(code), .boostCurrentMa(ma), .boostCodeValid(valid),
        .pdmClkIn(clkIn), .pdmDataIn(dataIn), .pdmClkOut(clkOut), .pdmClkOe(oe),
        .firstMicData(m1d), .firstMicValid(m1v), .secondMicData(m2d), .secondMicValid(m2v),
        .pdmClockError(err), .firstInputPulldown(pd1), .secondInputPulldown(pd2),
        .pdmDataPulldown(pdd), .pdmClockPulldown(pdc), .secondPortTransmitFill(fill),
        .secondPortBitclockRatio(ratio));
    atpc_mic_model mic (.core_clk(core_clk), .clkRun(clkRun), .pdmClkIn(clkIn),
        .pdmDataIn(dataIn));

    // 25 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // Pulse monitor on the falling edge, where outputs have settled
    always @(negedge core_clk) begin
        if (m1v) n1++;
        if (m2v) n2++;
        if (clkOut) hiCnt++;
        if (oe === 1'b1 && ((m1v && clkOut !== edgeLvl) || (m2v && clkOut === edgeLvl))) badEdge++;
        // Captured bit must be the pad level at the capture edge
        if ((m1v && m1d !== dataIn) || (m2v && m2d !== dataIn)) badEdge++;
    end

    task automatic chk(input string n, input logic [12:0] e, input logic [12:0] g);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s expected %0h seen %0h", n, e, g);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(negedge core_clk);
        regWrEn = 1'b0;
        repeat (2) @(negedge core_clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge core_clk);
        regRdEn = 1'b0;
        chk("regRdData", {5'h0, e}, {5'h0, regRdData});
        // Idle cycle so a following read raises a strobe that was really low
        @(negedge core_clk);
    endtask : rd

    // Counts negedges between two changes of the master clock
    task automatic halfp(input logic [12:0] e);
        logic s;
        int   c;
        for (int k = 0; k < 2; k++) begin
            s = clkOut;
            c = 0;
            while (clkOut === s && c < 50) begin
                @(negedge core_clk);
                c++;
            end
        end
        chk("halfPeriod", e, c[12:0]);
    endtask : halfp

    task automatic span(input int n);
        n1 = 0;
        n2 = 0;
        badEdge = 0;
        hiCnt = 0;
        repeat (n) @(negedge core_clk);
    endtask : span

    task automatic finish_test;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finish_test

    // Watchdog well beyond the expected run of about 600 cycles
    initial begin
        #200000;
        num_errors++;
        finish_test();
    end

    initial begin
        {nrst, regWrEn, regRdEn, pin0, pin1, pin2, clkRun, edgeLvl} = 8'h01;
        {regAddr, regWrData} = 16'h0;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        nrst = 1'b1;
        @(negedge core_clk);
        chk("boostCurrentMa", 13'd3960, ma);
        chk("boostCode", 13'h36, {7'h0, code});
        chk("secondPort", 13'h01, {8'h0, fill, ratio});
        chk("pdmClkOe", 0, oe);
        chk("vibrationModeOn", 0, vib);
        // Reset value, then write and read back each register
        for (i = 0; i < 7; i++) begin
            rd(rows[i][0], rows[i][1]);
            wr(rows[i][0], rows[i][2]);
            rd(rows[i][0], rows[i][3]);
        end
        chk("vibrationModeOn", 1, vib);
        chk("pulldowns", 13'hF, {9'h0, pd2, pd1, pdd, pdc});
        chk("boostCurrentMa", 13'd4000, ma);
        chk("boostCode", 13'h37, {7'h0, code});
        chk("secondPort", 13'h1F, {8'h0, fill, ratio});
        wr(OFS_BST, 8'h38);
        chk("boostCodeValid", 0, valid);
        chk("boostCode", 13'h38, {7'h0, code});
        wr(OFS_BST, 8'h00);
        chk("boostCurrentMa", 13'd990, ma);
        wr(OFS_BST, 8'h01);
        chk("boostCurrentMa", 13'd1045, ma);
        wr(OFS_MISC, 8'h00);
        chk("vibrationModeOn", 0, vib);
        wr(OFS_PULL, 8'h00);
        chk("pulldowns", 0, {9'h0, pd2, pd1, pdd, pdc});
        // Each trigger source against its own pin and against the other pins
        for (i = 0; i < 4; i++) begin
            wr(OFS_TONE, {2'b00, i[1:0], 4'h0});
            {pin2, pin1, pin0} = 3'h7 & ~(3'h1 << (i - 1));
            repeat (3) @(negedge core_clk);
            chk("toneActive", 0, toneAct);
            {pin2, pin1, pin0} = 3'h1 << (i - 1);
            repeat (3) @(negedge core_clk);
            chk("toneActive", {12'h0, i != 0}, toneAct);
        end
        {pin2, pin1, pin0} = 3'h0;
        wr(OFS_TONE, 8'h40);
        chk("toneActive", 1, toneAct);
        wr(OFS_TONE, 8'h80);
        chk("toneState", 13'h1, {11'h0, toneAct, toneLvl});
        // Master, both mics, both rates and both capture edges
        wr(OFS_PDM, 8'h42);
        chk("pdmClkOe", 1, oe);
        halfp(4);
        span(80);
        chk("micPulses", 13'h2, {11'h0, n1 > 0, n2 > 0});
        chk("edgeErrors", 0, badEdge[12:0]);
        edgeLvl = 1'b0;
        wr(OFS_PDM, 8'h6A);
        halfp(2);
        span(80);
        chk("edgeErrors", 0, badEdge[12:0]);
        edgeLvl = 1'b1;
        wr(OFS_PDM, 8'h44);
        span(80);
        chk("micPulses", 13'h1, {11'h0, n1 > 0, n2 > 0});
        chk("edgeErrors", 0, badEdge[12:0]);
        // Gated clock holds with both paths off, runs when gating is off
        wr(OFS_PDM, 8'h40);
        span(40);
        chk("gatedHighCycles", 0, hiCnt[12:0]);
        wr(OFS_PDM, 8'h00);
        halfp(4);
        // Follower: outside clock, then a stall with and without detection
        wr(OFS_PDM, 8'h03);
        clkRun = 1'b1;
        span(80);
        chk("followerState", 13'h1, {10'h0, oe, err, n1 > 0});
        chk("edgeErrors", 0, badEdge[12:0]);
        clkRun = 1'b0;
        repeat (40) @(negedge core_clk);
        chk("pdmClockError", 1, err);
        wr(OFS_PDM, 8'h13);
        repeat (40) @(negedge core_clk);
        chk("pdmClockError", 0, err);
        // Mid-run reset brings the registers home
        nrst = 1'b0;
        @(negedge core_clk);
        nrst = 1'b1;
        rd(OFS_PDM, RST_PDM);
        rd(OFS_BST, RST_BST);
        chk("pdmClockError", 0, err);
        finish_test();
    end
endmodule : tb_top
`default_nettype wire

//--- verilog/atpc_config_regs.sv
// Functional notes
// RULE1: Haptics mode follows the haptics enable bit, which resets to 0.
// RULE2: Tone enable code 00 is off or pin wait, 01 plays, 10 is audio level, 11 reserved.
// RULE3: Tone trigger source 00 none, 01 audio input, 10 general pin, 11 address pin.
// RULE4: Boost limit starts at 0.99 A for code 00h and climbs 55 mA per code.
// RULE5: Code 37h is 4 A and codes 38h to 3Fh are reserved for the host.
// RULE6: The six-bit boost limit field resets to 36h, a 3.96 A limit.
// RULE7: As master the PDM clock is gated when the gating bit is 1, reset 1; the code gates it only while both mic paths are off.
// RULE8: PDM rate is 3.072 MHz for rate bit 0 and 6.144 MHz for 1, reset 0.
// RULE9: Clock errors are detected while the disable bit is 0 and masked at 1; the code detects them only while a mic path is on.
// RULE10: Edge bit 0 samples mic one on rise and mic two on fall, 1 swaps them.
// RULE11: The second mic path runs only while bit 2 is 1, reset 0.
// RULE12: The first mic path runs only while bit 1 is 1, reset 0.
// RULE13: Role bit 0 makes the device drive the PDM clock, 1 takes it from outside.
// RULE14: Bits 7 and 6 enable weak pull-downs on audio inputs two and one.
// RULE15: Bits 4 and 3 enable pull-downs on the PDM data and clock pads.
// RULE16: Read-only reserved bits read their reset value and ignore writes.
`timescale 1ns/1ps
`default_nettype none
module atpc_config_regs (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        nrst,
    // Register access
    input  wire logic [7:0]  regAddr,
    input  wire logic        regWrEn,
    input  wire logic [7:0]  regWrData,
    input  wire logic        regRdEn,
    output logic      [7:0]  regRdData,
    // Tone and haptics
    input  wire logic        audioSerialInputPin,
    input  wire logic        gpioPin,
    input  wire logic        addressSelectPin,
    output logic             vibrationModeOn,
    output logic             toneActive,
    output logic             toneAudioLevel,
    // Boost limit
    output logic      [5:0]  boostPeakCurrentCode,
    output logic      [12:0] boostCurrentMa,
    output logic             boostCodeValid,
    // PDM pad
    input  wire logic        pdmClkIn,
    input  wire logic        pdmDataIn,
    output logic             pdmClkOut,
    output logic             pdmClkOe,
    output logic             firstMicData,
    output logic             firstMicValid,
    output logic             secondMicData,
    output logic             secondMicValid,
    output logic             pdmClockError,
    // Pad pull-downs
    output logic             firstInputPulldown,
    output logic             secondInputPulldown,
    output logic             pdmDataPulldown,
    output logic             pdmClockPulldown,
    // Second serial port
    output logic             secondPortTransmitFill,
    output logic      [3:0]  secondPortBitclockRatio
);
    import atpc_pkg::*;

    logic [7:0] miscQ, toneQ, bstQ, pdmQ, pullQ, sp2Q;
    logic [7:0] rdD;
    logic [2:0] halfCnt_q;
    logic       masterClk_q;
    logic       clkPrev_q;
    logic [4:0] errCnt_q;
    logic       anyMic, clkNow, rise, fall;
    logic       mic1Edge, mic2Edge, clkRun;
    atpc_tone_t toneCode;
    logic [1:0] toneSrc;
    logic       pinHit;

    // Register writes; masks keep read-only bits at reset
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            miscQ <= RST_MISC;  // RULE1
            toneQ <= RST_TONE;
            bstQ  <= RST_BST;   // RULE6
            pdmQ  <= RST_PDM;   // RULE7
            pullQ <= RST_PULL;
            sp2Q  <= RST_SP2;
        end else if (regWrEn) begin
            case (regAddr)
                OFS_MISC: miscQ <= regWrData;
                OFS_TONE: toneQ <= (regWrData & WMSK_TONE) | (RST_TONE & ~WMSK_TONE); // RULE16
                OFS_BST:  bstQ  <= regWrData;
                OFS_PDM:  pdmQ  <= (regWrData & WMSK_PDM) | (RST_PDM & ~WMSK_PDM);    // RULE16
                OFS_PULL: pullQ <= (regWrData & WMSK_PULL) | (RST_PULL & ~WMSK_PULL); // RULE16
                OFS_SP2:  sp2Q  <= (regWrData & WMSK_SP2) | (RST_SP2 & ~WMSK_SP2);    // RULE16
                default: ;
            endcase
        end
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        case (regAddr)
            OFS_MISC: rdD = miscQ;
            OFS_TONE: rdD = toneQ;
            OFS_BST:  rdD = bstQ;
            OFS_PDM:  rdD = pdmQ;
            OFS_PULL: rdD = pullQ;
            OFS_SP2:  rdD = sp2Q;
            default:  rdD = 8'h00;
        endcase
    end

    // Read data held until the next read
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            regRdData <= 8'h00;
        end else if (regRdEn) begin
            regRdData <= rdD;
        end
    end

    // Tone trigger selection
    assign toneCode = atpc_tone_t'(toneQ[POS_TONE_EN +: 2]);
    assign toneSrc  = toneQ[POS_TONE_SRC +: 2];
    always_comb begin
        case (toneSrc)
            2'h1:    pinHit = audioSerialInputPin; // RULE3
            2'h2:    pinHit = gpioPin;             // RULE3
            2'h3:    pinHit = addressSelectPin;    // RULE3
            default: pinHit = 1'b0;
        endcase
    end

    // Mode and tone outputs; reserved tone code plays nothing
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            vibrationModeOn <= 1'b0;
            toneActive      <= 1'b0;
            toneAudioLevel  <= 1'b0;
        end else begin
            vibrationModeOn <= miscQ[BIT_HAPTIC]; // RULE1
            case (toneCode)
                TONE_PLAY: toneActive <= 1'b1;    // RULE2
                TONE_OFF:  toneActive <= pinHit;  // RULE2
                default:   toneActive <= 1'b0;
            endcase
            toneAudioLevel <= (toneCode == TONE_LEVEL); // RULE2
        end
    end

    // Boost limit; reserved codes report the 4 A ceiling
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            boostPeakCurrentCode <= RST_BST[5:0];
            // Reset code 36h shows its own limit, not the ceiling
            boostCurrentMa       <= BST_BASE_MA + BST_STEP_MA * 13'(RST_BST[5:0]); // RULE6
            boostCodeValid       <= 1'b1;
        end else begin
            boostPeakCurrentCode <= bstQ[5:0];
            boostCodeValid       <= (bstQ[5:0] <= BST_MAX_CODE); // RULE5
            if (bstQ[5:0] >= BST_MAX_CODE) begin
                boostCurrentMa <= BST_TOP_MA; // RULE5
            end else begin
                boostCurrentMa <= BST_BASE_MA + BST_STEP_MA * {7'h00, bstQ[5:0]}; // RULE4
            end
        end
    end

    // Master clock divider, parked low while gated
    assign anyMic = pdmQ[BIT_FIRST_MICROPHONE] | pdmQ[BIT_SECOND_MICROPHONE];
    assign clkRun = !pdmQ[BIT_ROLE] && (anyMic || !pdmQ[BIT_GATE]); // RULE7 RULE13
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            halfCnt_q   <= 3'h0;
            masterClk_q <= 1'b0;
        end else if (!clkRun) begin
            halfCnt_q   <= 3'h0;
            masterClk_q <= 1'b0; // RULE7
        end else if (halfCnt_q == 3'(pdmQ[BIT_RATE] ? HALF_HI - 1 : HALF_LO - 1)) begin // RULE8
            halfCnt_q   <= 3'h0;
            masterClk_q <= !masterClk_q;
        end else begin
            halfCnt_q <= halfCnt_q + 3'h1;
        end
    end

    // Pad drive: master drives the clock, follower listens
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pdmClkOut <= 1'b0;
            pdmClkOe  <= 1'b0;
        end else begin
            pdmClkOut <= masterClk_q;
            pdmClkOe  <= !pdmQ[BIT_ROLE]; // RULE13
        end
    end

    // Edge detect on the clock in use; inputs are synchronous
    assign clkNow   = pdmQ[BIT_ROLE] ? pdmClkIn : masterClk_q; // RULE13
    assign rise     = clkNow & ~clkPrev_q;
    assign fall     = ~clkNow & clkPrev_q;
    assign mic1Edge = pdmQ[BIT_EDGE] ? fall : rise; // RULE10
    assign mic2Edge = pdmQ[BIT_EDGE] ? rise : fall; // RULE10

    // Microphone capture, one valid pulse per edge
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            clkPrev_q      <= 1'b0;
            firstMicData   <= 1'b0;
            firstMicValid  <= 1'b0;
            secondMicData  <= 1'b0;
            secondMicValid <= 1'b0;
        end else begin
            clkPrev_q      <= clkNow;
            firstMicValid  <= mic1Edge & pdmQ[BIT_FIRST_MICROPHONE]; // RULE12
            secondMicValid <= mic2Edge & pdmQ[BIT_SECOND_MICROPHONE]; // RULE11
            if (mic1Edge & pdmQ[BIT_FIRST_MICROPHONE]) begin
                firstMicData <= pdmDataIn;
            end
            if (mic2Edge & pdmQ[BIT_SECOND_MICROPHONE]) begin
                secondMicData <= pdmDataIn;
            end
        end
    end

    // Missing-clock watchdog; a stopped clock is only an error while mics listen
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            errCnt_q      <= 5'h0;
            pdmClockError <= 1'b0;
        end else if (pdmQ[BIT_ERRDIS] || !anyMic || rise || fall) begin
            errCnt_q      <= 5'h0;
            pdmClockError <= 1'b0; // RULE9
        end else if (errCnt_q == 5'(ERR_CYC - 1)) begin
            pdmClockError <= 1'b1; // RULE9
        end else begin
            errCnt_q <= errCnt_q + 5'h1;
        end
    end

    // Pad pull-downs and second port fields
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            secondInputPulldown     <= 1'b0;
            firstInputPulldown      <= 1'b0;
            pdmDataPulldown         <= 1'b0;
            pdmClockPulldown        <= 1'b0;
            secondPortTransmitFill  <= 1'b0;
            secondPortBitclockRatio <= RST_SP2[POS_SP2_RAT +: 4];
        end else begin
            secondInputPulldown     <= pullQ[BIT_PD_IN2];  // RULE14
            firstInputPulldown      <= pullQ[BIT_PD_IN1];  // RULE14
            pdmDataPulldown         <= pullQ[BIT_PD_DATA]; // RULE15
            pdmClockPulldown        <= pullQ[BIT_PD_CLK];  // RULE15
            secondPortTransmitFill  <= sp2Q[BIT_SP2_FILL];
            secondPortBitclockRatio <= sp2Q[POS_SP2_RAT +: 4];
        end
    end

    // Checks
    a_haptic_write: assert property (@(posedge core_clk) disable iff (!nrst) // RULE1
        regWrEn && regAddr == OFS_MISC |=> ##1 vibrationModeOn == $past(regWrData[7], 2))
        else $error("haptics mode did not follow write");
    a_tone_play: assert property (@(posedge core_clk) disable iff (!nrst) // RULE2
        toneCode == TONE_PLAY |=> toneActive) else $error("tone not playing");
    a_tone_idle: assert property (@(posedge core_clk) disable iff (!nrst) // RULE3
        toneCode == TONE_OFF && toneSrc == 2'h0 |=> !toneActive)
        else $error("tone active without trigger");
    a_boost_step: assert property (@(posedge core_clk) disable iff (!nrst) // RULE4
        bstQ[5:0] == 6'h01 |=> boostCurrentMa == 13'd1045) else $error("boost step wrong");
    a_boost_rsvd: assert property (@(posedge core_clk) disable iff (!nrst) // RULE5
        bstQ[5:0] > BST_MAX_CODE |=> !boostCodeValid) else $error("reserved code valid");
    a_clock_gated: assert property (@(posedge core_clk) disable iff (!nrst) // RULE7
        (!pdmQ[BIT_ROLE] && pdmQ[BIT_GATE] && !anyMic)[*3] |=> !pdmClkOut)
        else $error("gated clock toggles");
    a_error_mask: assert property (@(posedge core_clk) disable iff (!nrst) // RULE9
        pdmQ[BIT_ERRDIS] |=> !pdmClockError) else $error("masked error reported");
    a_role_drive: assert property (@(posedge core_clk) disable iff (!nrst) // RULE13
        pdmQ[BIT_ROLE] |=> !pdmClkOe) else $error("follower drives clock");
    a_first_microphone_gate: assert property (@(posedge core_clk) disable iff (!nrst) // RULE12
        !pdmQ[BIT_FIRST_MICROPHONE] |=> !firstMicValid) else $error("mic one valid while off");
    a_rsvd_read: assert property (@(posedge core_clk) disable iff (!nrst) // RULE16
        regRdEn && regAddr == OFS_TONE |=> regRdData[3:0] == 4'h0)
        else $error("reserved tone bits read nonzero");
    c_mic_capture: cover property (@(posedge core_clk) firstMicValid ##1 secondMicValid);
    c_clock_error: cover property (@(posedge core_clk) pdmClockError);
    c_pin_tone: cover property (@(posedge core_clk) toneCode == TONE_OFF ##1 toneActive);
endmodule : atpc_config_regs
`default_nettype wire
